// File: verilog/freq_phase_pkg.sv
package freq_phase_pkg;

  // ***************************************************************
  // Widths, register map and reset values
  // ***************************************************************
  localparam int          FREQ_W        = 32;
  localparam int          PHASE_W       = 5;
  localparam int          WORD_W        = 40;
  localparam logic [4:0]  PHASE_MAX     = 5'h1F;
  localparam logic [31:0] FREQ_RESET    = 32'h00008637;
  localparam logic [31:0] HOLD_RESET    = 32'h00008637;
  localparam logic [4:0]  PHASE_RESET   = 5'h00;
  // Phase step in hundredths of a degree
  localparam int          PHASE_STEP_CDEG = 1125;

  localparam logic [11:0] OFF_HOLD      = 12'h000;
  localparam logic [11:0] OFF_CMD       = 12'h004;
  localparam logic [11:0] OFF_AFREQ     = 12'h008;
  localparam logic [11:0] OFF_BFREQ     = 12'h00C;
  localparam logic [11:0] OFF_PHASE     = 12'h010;
  localparam logic [11:0] OFF_STATUS    = 12'h014;
  localparam logic [11:0] OFF_CONV      = 12'h018;
  localparam logic [11:0] OFF_WORDA_LO  = 12'h01C;
  localparam logic [11:0] OFF_WORDB_LO  = 12'h020;
  localparam logic [11:0] OFF_WORD_HI   = 12'h024;

  // Command codes written to the command register
  localparam logic [3:0]  CMD_OUT_BOTH  = 4'h1;
  localparam logic [3:0]  CMD_OUT_A     = 4'h2;
  localparam logic [3:0]  CMD_OUT_B     = 4'h3;
  localparam logic [3:0]  CMD_LOAD_A    = 4'h4;
  localparam logic [3:0]  CMD_LOAD_B    = 4'h5;
  localparam logic [3:0]  CMD_UP_A      = 4'h6;
  localparam logic [3:0]  CMD_UP_B      = 4'h7;
  localparam logic [3:0]  CMD_DOWN_A    = 4'h8;
  localparam logic [3:0]  CMD_DOWN_B    = 4'h9;
  localparam logic [3:0]  CMD_PHASE_A   = 4'hA;
  localparam logic [3:0]  CMD_PHASE_B   = 4'hB;

endpackage

// File: verilog/dds_freq_phase_command_unit.sv
// Overview of operation
// - Output-A sends stored A frequency unchanged
// - Load-output copies hex or converted decimal
// - Flag remembers decimal or hex entry
// - Upward adjust adds holding to frequency
// - Adjusts never update synthesizer outputs
// - Downward adjust negates holding, then adds
// - Repeated downward adjusts alternate sign
// - Phase commands store phase only, no output update
// - Phase clipped to 31 without error
// - One phase unit is 11.25 degrees
// - Report shows phase as p and hex
// - Output commands send both synchronized words
// - Holding load also clears the decimal flag, changes nothing else
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
module dds_freq_phase_command_unit (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [39:0] synthWordA,
  output logic      [39:0] synthWordB,
  output logic             synth_word_update_strobe
);

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  logic        wrEn;
  logic        rdEn;
  logic        hit;
  assign pready  = 1'b1;
  assign wrEn    = psel & penable & pwrite;
  assign rdEn    = psel & penable & ~pwrite;
  always_comb begin
    unique case (paddr)
      freq_phase_pkg::OFF_HOLD,  freq_phase_pkg::OFF_CMD,   freq_phase_pkg::OFF_AFREQ,
      freq_phase_pkg::OFF_BFREQ, freq_phase_pkg::OFF_PHASE, freq_phase_pkg::OFF_STATUS,
      freq_phase_pkg::OFF_CONV,  freq_phase_pkg::OFF_WORDA_LO, freq_phase_pkg::OFF_WORDB_LO,
      freq_phase_pkg::OFF_WORD_HI: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [31:0] hold_r,  hold_nxt;
  logic        isDec_r, isDec_nxt;
  logic [31:0] conv_r,  conv_nxt;
  logic [31:0] aFreq_r, aFreq_nxt;
  logic [31:0] bFreq_r, bFreq_nxt;
  logic [4:0]  aPhase_r, aPhase_nxt;
  logic [4:0]  bPhase_r, bPhase_nxt;
  logic [39:0] wordA_r, wordA_nxt;
  logic [39:0] wordB_r, wordB_nxt;
  logic        strobe_r, strobe_nxt;
  logic [31:0] rd_nxt;
  logic [3:0]  cmd;
  logic        cmdWr;
  logic [31:0] loadVal;
  logic [31:0] negHold;
  logic [4:0]  clipPhase;

  assign cmd       = pwdata[3:0];
  assign cmdWr     = wrEn && (paddr == freq_phase_pkg::OFF_CMD);
  assign loadVal   = isDec_r ? conv_r : hold_r;
  assign negHold   = 32'(~hold_r + 32'h00000001);
  assign clipPhase = (hold_r > 32'(freq_phase_pkg::PHASE_MAX))
                     ? freq_phase_pkg::PHASE_MAX : hold_r[4:0];

  always_comb begin
    hold_nxt   = hold_r;
    isDec_nxt  = isDec_r;
    conv_nxt   = conv_r;
    aFreq_nxt  = aFreq_r;
    bFreq_nxt  = bFreq_r;
    aPhase_nxt = aPhase_r;
    bPhase_nxt = bPhase_r;
    wordA_nxt  = wordA_r;
    wordB_nxt  = wordB_r;
    strobe_nxt = 1'b0;
    // Holding entry clears the decimal flag, touches nothing else
    if (wrEn && paddr == freq_phase_pkg::OFF_HOLD) begin
      hold_nxt  = pwdata;
      isDec_nxt = 1'b0;
    end
    if (wrEn && paddr == freq_phase_pkg::OFF_STATUS) begin
      isDec_nxt = pwdata[0];
    end
    if (wrEn && paddr == freq_phase_pkg::OFF_CONV) begin
      conv_nxt = pwdata;
    end
    if (cmdWr) begin
      unique case (cmd)
        freq_phase_pkg::CMD_LOAD_A: aFreq_nxt = loadVal;
        freq_phase_pkg::CMD_LOAD_B: bFreq_nxt = loadVal;
        freq_phase_pkg::CMD_UP_A:   aFreq_nxt = 32'(aFreq_r + hold_r);
        freq_phase_pkg::CMD_UP_B:   bFreq_nxt = 32'(bFreq_r + hold_r);
        freq_phase_pkg::CMD_DOWN_A: begin
          hold_nxt  = negHold;
          aFreq_nxt = 32'(aFreq_r + negHold);
        end
        freq_phase_pkg::CMD_DOWN_B: begin
          hold_nxt  = negHold;
          bFreq_nxt = 32'(bFreq_r + negHold);
        end
        freq_phase_pkg::CMD_PHASE_A: aPhase_nxt = clipPhase;
        freq_phase_pkg::CMD_PHASE_B: bPhase_nxt = clipPhase;
        default: ;
      endcase
      // Every output command pushes both words together
      unique case (cmd)
        freq_phase_pkg::CMD_OUT_BOTH, freq_phase_pkg::CMD_OUT_A, freq_phase_pkg::CMD_OUT_B: begin
          wordA_nxt  = {aPhase_r, 3'h0, aFreq_r};
          wordB_nxt  = {bPhase_r, 3'h0, bFreq_r};
          strobe_nxt = 1'b1;
        end
        freq_phase_pkg::CMD_LOAD_A: begin
          wordA_nxt  = {aPhase_r, 3'h0, loadVal};
          wordB_nxt  = {bPhase_r, 3'h0, bFreq_r};
          strobe_nxt = 1'b1;
        end
        freq_phase_pkg::CMD_LOAD_B: begin
          wordA_nxt  = {aPhase_r, 3'h0, aFreq_r};
          wordB_nxt  = {bPhase_r, 3'h0, loadVal};
          strobe_nxt = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    if (rdEn) begin
      unique case (paddr)
        freq_phase_pkg::OFF_HOLD:     rd_nxt = hold_r;
        freq_phase_pkg::OFF_AFREQ:    rd_nxt = aFreq_r;
        freq_phase_pkg::OFF_BFREQ:    rd_nxt = bFreq_r;
        // Report form: p then two hex digits per phase
        freq_phase_pkg::OFF_PHASE:    rd_nxt = {8'h70, 3'h0, aPhase_r, 8'h70, 3'h0, bPhase_r};
        freq_phase_pkg::OFF_STATUS:   rd_nxt = {31'h00000000, isDec_r};
        freq_phase_pkg::OFF_CONV:     rd_nxt = conv_r;
        freq_phase_pkg::OFF_WORDA_LO: rd_nxt = wordA_r[31:0];
        freq_phase_pkg::OFF_WORDB_LO: rd_nxt = wordB_r[31:0];
        freq_phase_pkg::OFF_WORD_HI:  rd_nxt = {16'h0000, wordB_r[39:32], wordA_r[39:32]};
        default:                      rd_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_r   <= freq_phase_pkg::HOLD_RESET;
      isDec_r  <= 1'b0;
      conv_r   <= 32'h00000000;
      aFreq_r  <= freq_phase_pkg::FREQ_RESET;
      bFreq_r  <= freq_phase_pkg::FREQ_RESET;
      aPhase_r <= freq_phase_pkg::PHASE_RESET;
      bPhase_r <= freq_phase_pkg::PHASE_RESET;
      wordA_r  <= 40'h0000000000;
      wordB_r  <= 40'h0000000000;
      strobe_r <= 1'b0;
    end else begin
      hold_r   <= hold_nxt;
      isDec_r  <= isDec_nxt;
      conv_r   <= conv_nxt;
      aFreq_r  <= aFreq_nxt;
      bFreq_r  <= bFreq_nxt;
      aPhase_r <= aPhase_nxt;
      bPhase_r <= bPhase_nxt;
      wordA_r  <= wordA_nxt;
      wordB_r  <= wordB_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  assign prdata                   = rd_nxt;
  assign synthWordA               = wordA_r;
  assign synthWordB               = wordB_r;
  assign synth_word_update_strobe = strobe_r;

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence cmdSeq(logic [3:0] c);
    cmdWr && cmd == c;
  endsequence

  // Any of the three plain output commands
  sequence outSeq;
    cmdWr && (cmd == freq_phase_pkg::CMD_OUT_BOTH || cmd == freq_phase_pkg::CMD_OUT_A ||
              cmd == freq_phase_pkg::CMD_OUT_B);
  endsequence

  // Command code outside the decoded set
  sequence unknownSeq;
    cmdWr && (cmd == 4'h0 || cmd > freq_phase_pkg::CMD_PHASE_B);
  endsequence

  AST_OUT_A_UNCHANGED: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_OUT_A) |=> synthWordA[31:0] == $past(aFreq_r) && synth_word_update_strobe)
    else $error("output A did not send stored A frequency");

  AST_LOAD_A: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_LOAD_A) |=> aFreq_r == synthWordA[31:0] && synth_word_update_strobe)
    else $error("load A mismatch");

  AST_LOAD_B: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_LOAD_B) && isDec_r |=> bFreq_r == $past(conv_r)
    && synthWordB[31:0] == $past(conv_r) && synth_word_update_strobe)
    else $error("decimal load B did not use converted value");

  AST_HEX_DIRECT: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_LOAD_B) && !isDec_r |=> bFreq_r == $past(hold_r))
    else $error("hex entry not loaded directly");

  AST_HEX_A: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_LOAD_A) && !isDec_r |=> aFreq_r == $past(hold_r))
    else $error("hex entry not loaded directly into A");

  AST_UP_ADD: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_UP_B) |=> bFreq_r == 32'($past(bFreq_r) + $past(hold_r)))
    else $error("upward adjust sum wrong");

  AST_ADJ_NO_OUT: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_UP_A) or cmdSeq(freq_phase_pkg::CMD_DOWN_B)
    |=> !synth_word_update_strobe && $stable(synthWordA) && $stable(synthWordB))
    else $error("adjust touched outputs");

  AST_DOWN_NEG: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_DOWN_A) |=> hold_r == 32'(~$past(hold_r) + 32'h00000001)
    && aFreq_r == 32'($past(aFreq_r) - $past(hold_r)))
    else $error("downward adjust wrong");

  AST_DOWN_B_SUM: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_DOWN_B) |=> bFreq_r == 32'($past(bFreq_r) - $past(hold_r)))
    else $error("downward adjust of B wrong");

  AST_DOWN_TOGGLE: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_DOWN_B) |=> 32'(hold_r + $past(hold_r)) == 32'h00000000)
    else $error("holding value not negated for next adjust");

  AST_PHASE_A_STORE: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_PHASE_A) && hold_r < 32'h00000020
    |=> aPhase_r == $past(hold_r[4:0]) && !synth_word_update_strobe)
    else $error("phase A not stored");

  AST_PHASE_B_STORE: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_PHASE_B) && hold_r < 32'h00000020 |=> bPhase_r == $past(hold_r[4:0]))
    else $error("phase B not stored");

  AST_PHASE_CLIP: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_PHASE_B) && hold_r > 32'h0000001F |=> bPhase_r == 5'h1F)
    else $error("phase not clipped");

  AST_PHASE_FIELD: assert property (@(posedge core_clk) disable iff (rst)
    synth_word_update_strobe |-> synthWordA[39:35] == aPhase_r && synthWordA[34:32] == 3'h0
    && synthWordB[39:35] == bPhase_r && synthWordB[34:32] == 3'h0)
    else $error("phase field of synthesizer word wrong");

  AST_REPORT: assert property (@(posedge core_clk) disable iff (rst)
    rdEn && paddr == freq_phase_pkg::OFF_PHASE |-> prdata[31:24] == 8'h70 && prdata[15:8] == 8'h70
    && prdata[20:16] == aPhase_r && prdata[4:0] == bPhase_r)
    else $error("phase report wrong");

  AST_BOTH_WORDS: assert property (@(posedge core_clk) disable iff (rst)
    outSeq |=> synthWordB == {$past(bPhase_r), 3'h0, $past(bFreq_r)}
    && synthWordA == {$past(aPhase_r), 3'h0, $past(aFreq_r)} && synth_word_update_strobe)
    else $error("output command did not send both words");

  AST_UNKNOWN_CMD: assert property (@(posedge core_clk) disable iff (rst)
    unknownSeq |=> !synth_word_update_strobe && $stable(aFreq_r) && $stable(bFreq_r) && $stable(hold_r))
    else $error("unknown command changed state");

  AST_HOLD_ONLY: assert property (@(posedge core_clk) disable iff (rst)
    wrEn && paddr == freq_phase_pkg::OFF_HOLD |=> $stable(aFreq_r) && $stable(bFreq_r)
    && $stable(synthWordA) && !synth_word_update_strobe)
    else $error("holding write changed other state");

  AST_UP_WRAP: assert property (@(posedge core_clk) disable iff (rst)
    cmdSeq(freq_phase_pkg::CMD_UP_A) |=> aFreq_r == 32'($past(aFreq_r) + $past(hold_r)))
    else $error("upward adjust of A did not wrap");

  AST_RESET_PHASE: assert property (@(posedge core_clk)
    $fell(rst) |-> aPhase_r == 5'h00 && bPhase_r == 5'h00)
    else $error("phases not zero after reset");

endmodule

// File: tb/synth_pair_model.sv
`timescale 1ns/100ps
module synth_pair_model (
  input  wire logic        core_clk,
  input  wire logic [39:0] synthWordA,
  input  wire logic [39:0] synthWordB,
  input  wire logic        synth_word_update_strobe,
  output logic      [39:0] heldA,
  output logic      [39:0] heldB
);
  // Both chips latch on the shared strobe
  always @(posedge core_clk) begin
    if (synth_word_update_strobe) begin
      heldA <= synthWordA;
      heldB <= synthWordB;
    end
  end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr    = '0;
  logic [31:0] pwdata   = '0, prdata;
  logic        pready, pslverr, strobe;
  logic [39:0] wA, wB, hA, hB;
  logic [31:0] af       = 32'h8637, bf = 32'h8637, hd = 32'h8637, cv = 32'h0;
  logic [4:0]  ap       = 5'h0, bp = 5'h0;
  logic        dec      = 0;
  logic [79:0] lastW;
  logic [32:0] rdq[$];
  logic [79:0] wq[$];
  int          error_cnt = 0, n_compared = 0;

  dds_freq_phase_command_unit u_dds_freq_phase_command_unit (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .synthWordA(wA), .synthWordB(wB), .synth_word_update_strobe(strobe));
  synth_pair_model u_synth_pair_model (.core_clk(core_clk), .synthWordA(wA), .synthWordB(wB),
    .synth_word_update_strobe(strobe), .heldA(hA), .heldB(hB));

  always #20 core_clk = ~core_clk;

  // ****************************************************
  // Checking and bus tasks
  // ****************************************************
  task check(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("Compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      conclude();
    end else begin
      psel <= 0;
      penable <= 0;
    end
  endtask

  task rd(input logic [11:0] a, input logic [32:0] e);
    rdq.push_back(e);
    apb(0, a, 32'h0);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    if (a == 12'h000) begin
      hd = d;
      dec = 0;
    end
    if (a == 12'h014) dec = d[0];
    if (a == 12'h018) cv = d;
    apb(1, a, d);
  endtask

  task cmd(input logic [3:0] c);
    case (c)
      4'h4: af = dec ? cv : hd;
      4'h5: bf = dec ? cv : hd;
      4'h6: af = af + hd;
      4'h7: bf = bf + hd;
      4'h8: begin hd = -hd; af = af + hd; end
      4'h9: begin hd = -hd; bf = bf + hd; end
      4'hA: ap = (hd > 31) ? 5'h1F : hd[4:0];
      4'hB: bp = (hd > 31) ? 5'h1F : hd[4:0];
      default: ;
    endcase
    if (c >= 4'h1 && c <= 4'h5) begin
      lastW = {ap, 3'h0, af, bp, 3'h0, bf};
      wq.push_back(lastW);
    end
    apb(1, 12'h004, {28'h0, c});
  endtask

  task chk;
    rd(12'h008, {1'b0, af});
    rd(12'h00C, {1'b0, bf});
    rd(12'h000, {1'b0, hd});
    rd(12'h010, {1'b0, 8'h70, 3'h0, ap, 8'h70, 3'h0, bp});
  endtask

  // ****************************************************
  // Output monitor
  // ****************************************************
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite)
      check({47'h0, pslverr, prdata}, {47'h0, rdq.pop_front()});
    if (strobe)
      check({wA, wB}, (wq.size() > 0) ? wq.pop_front() : 80'hX);
  end

  // ****************************************************
  // Stimulus
  // ****************************************************
  initial begin
    void'($urandom(32'h030A9384));
    repeat (4) @(posedge core_clk);
    rst <= 0;
    chk;
    cmd(4'h2);
    wr(12'h000, 32'h0192A7);
    chk;
    cmd(4'h4);
    wr(12'h000, 32'h00AA);
    cmd(4'h8);
    cmd(4'h8);
    cmd(4'h6);
    chk;
    wr(12'h000, 32'h8);
    cmd(4'hA);
    wr(12'h000, 32'h20);
    cmd(4'hB);
    cmd(4'h1);
    chk;
    rd(12'h100, {1'b1, 32'h0});
    rd(12'h004, 33'h0);
    cmd(4'hF);
    repeat (60) begin
      wr(12'h000, $urandom_range(1) ? $urandom : $urandom_range(40));
      if ($urandom_range(1)) begin
        wr(12'h014, 32'h1);
        wr(12'h018, $urandom);
      end
      cmd(4'($urandom_range(11, 1)));
      chk;
    end
    repeat (3) @(posedge core_clk);
    check(80'(wq.size()), 80'h0);
    check({hA, hB}, lastW);
    conclude();
  end
endmodule
